// ### pkg/srsr_params.svh
// Purpose: Offsets, field positions and reset values of the result and status registers
// Assumes: 8-bit register addresses and 8-bit data
// Notes: Definitions only
`ifndef SRSR_PARAMS_SVH
`define SRSR_PARAMS_SVH
`define SRSR_ADDR_PROX2_LO 8'h28
`define SRSR_ADDR_PROX2_HI 8'h29
`define SRSR_ADDR_PROX3_LO 8'h2A
`define SRSR_ADDR_PROX3_HI 8'h2B
`define SRSR_ADDR_AUX_LO 8'h2C
`define SRSR_ADDR_AUX_HI 8'h2D
`define SRSR_ADDR_MAILBOX 8'h2E
`define SRSR_ADDR_PSTAT 8'h30
`define SRSR_RESULT_RESET 8'h00
`define SRSR_PSTAT_RESET 8'h00
`define SRSR_BIT_AWAKE 2
`define SRSR_BIT_WAIT 1
`define SRSR_BIT_LOWEST 0
`define SRSR_IRQ_BITS 6
`endif

// ### pkg/srsr_pkg.sv
// Purpose: Types for the result and status register slice
// Assumes: Constants come from srsr_params.svh
// Notes: Nothing is imported by users
package srsr_pkg;
   typedef enum logic [2:0] {
      SRSR_LOWEST = 3'h1,
      SRSR_WAIT = 3'h2,
      SRSR_AWAKE = 3'h4
   } srsr_pstate_type;
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } srsr_req_type;
   typedef struct packed {
      logic valid;
      logic [15:0] prox2;
      logic [15:0] prox3;
      logic [15:0] aux;
   } srsr_result_type;
endpackage

// ### src/srsr_regs.sv
// Purpose: Result words, parameter mailbox, power-state status and interrupt pin
// Assumes: Register requests arrive from the serial slave synchronous to clock_i
// Notes: Read data is registered, one cycle after the request
`include "srsr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module srsr_regs #(
   parameter int IRQ_BITS = `SRSR_IRQ_BITS
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic req_valid_i,
   input wire srsr_pkg::srsr_req_type req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   input wire srsr_pkg::srsr_result_type result_i,
   input wire logic mbox_load_i,
   input wire logic [7:0] mbox_data_i,
   input wire srsr_pkg::srsr_pstate_type pstate_i,
   input wire logic [IRQ_BITS-1:0] irq_status_i,
   input wire logic [IRQ_BITS-1:0] irq_enable_i,
   output logic int_o
);
   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   logic [7:0] p2l_ff, p2h_ff, p3l_ff, p3h_ff, axl_ff, axh_ff, mbox_ff, pstat_ff;
   logic [7:0] nxt_p2l, nxt_p2h, nxt_p3l, nxt_p3h, nxt_axl, nxt_axh, nxt_mbox, nxt_pstat;
   logic [7:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid, int_ff, nxt_int;
   logic wr;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      wr = req_valid_i && req_i.we;
      nxt_p2l = p2l_ff;
      nxt_p2h = p2h_ff;
      nxt_p3l = p3l_ff;
      nxt_p3h = p3h_ff;
      nxt_axl = axl_ff;
      nxt_axh = axh_ff;
      nxt_mbox = mbox_ff;
      // Host writes are allowed; a new measurement overwrites them, so results must be read in time
      if (wr && hit(req_i.addr, `SRSR_ADDR_PROX2_LO)) nxt_p2l = req_i.wdata;
      if (wr && hit(req_i.addr, `SRSR_ADDR_PROX2_HI)) nxt_p2h = req_i.wdata;
      if (wr && hit(req_i.addr, `SRSR_ADDR_PROX3_LO)) nxt_p3l = req_i.wdata;
      if (wr && hit(req_i.addr, `SRSR_ADDR_PROX3_HI)) nxt_p3h = req_i.wdata;
      if (wr && hit(req_i.addr, `SRSR_ADDR_AUX_LO)) nxt_axl = req_i.wdata;
      if (wr && hit(req_i.addr, `SRSR_ADDR_AUX_HI)) nxt_axh = req_i.wdata;
      if (wr && hit(req_i.addr, `SRSR_ADDR_MAILBOX)) nxt_mbox = req_i.wdata;
      // Engine wins over a host write in the same cycle
      if (result_i.valid) begin
         nxt_p2l = result_i.prox2[7:0];
         nxt_p2h = result_i.prox2[15:8];
         nxt_p3l = result_i.prox3[7:0];
         nxt_p3h = result_i.prox3[15:8];
         nxt_axl = result_i.aux[7:0];
         nxt_axh = result_i.aux[15:8];
      end
      if (mbox_load_i) nxt_mbox = mbox_data_i;
      nxt_pstat = 8'h00;
      unique case (pstate_i)
         srsr_pkg::SRSR_AWAKE: nxt_pstat[`SRSR_BIT_AWAKE] = 1'b1;
         srsr_pkg::SRSR_WAIT: nxt_pstat[`SRSR_BIT_WAIT] = 1'b1;
         srsr_pkg::SRSR_LOWEST: nxt_pstat[`SRSR_BIT_LOWEST] = 1'b1;
         // Illegal code reports no state rather than several
         default: nxt_pstat = 8'h00;
      endcase
      nxt_rvalid = req_valid_i && !req_i.we;
      nxt_rdata = 8'h00;
      if (req_valid_i && !req_i.we) begin
         unique case (req_i.addr)
            `SRSR_ADDR_PROX2_LO: nxt_rdata = p2l_ff;
            `SRSR_ADDR_PROX2_HI: nxt_rdata = p2h_ff;
            `SRSR_ADDR_PROX3_LO: nxt_rdata = p3l_ff;
            `SRSR_ADDR_PROX3_HI: nxt_rdata = p3h_ff;
            `SRSR_ADDR_AUX_LO: nxt_rdata = axl_ff;
            `SRSR_ADDR_AUX_HI: nxt_rdata = axh_ff;
            `SRSR_ADDR_MAILBOX: nxt_rdata = mbox_ff;
            `SRSR_ADDR_PSTAT: nxt_rdata = pstat_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
      nxt_int = |(irq_status_i & irq_enable_i);
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         p2l_ff <= `SRSR_RESULT_RESET;
         p2h_ff <= `SRSR_RESULT_RESET;
         p3l_ff <= `SRSR_RESULT_RESET;
         p3h_ff <= `SRSR_RESULT_RESET;
         axl_ff <= `SRSR_RESULT_RESET;
         axh_ff <= `SRSR_RESULT_RESET;
         mbox_ff <= `SRSR_RESULT_RESET;
         pstat_ff <= `SRSR_PSTAT_RESET;
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
         int_ff <= 1'b0;
      end else begin
         p2l_ff <= nxt_p2l;
         p2h_ff <= nxt_p2h;
         p3l_ff <= nxt_p3l;
         p3h_ff <= nxt_p3h;
         axl_ff <= nxt_axl;
         axh_ff <= nxt_axh;
         mbox_ff <= nxt_mbox;
         pstat_ff <= nxt_pstat;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
         int_ff <= nxt_int;
      end
   end

   assign rdata_o = rdata_ff;
   assign rvalid_o = rvalid_ff;
   assign int_o = int_ff;

   // ****************************************
   // Checks
   // ****************************************
   // Engine load and host requests are named once; s_result_load serves only chk_prox2_load, and chk_read_back spells its read out
   sequence s_result_load;
      result_i.valid;
   endsequence
   sequence s_host_write(logic [7:0] a);
      req_valid_i && req_i.we && req_i.addr == a;
   endsequence
   sequence s_host_read(logic [7:0] a);
      req_valid_i && !req_i.we && req_i.addr == a;
   endsequence
   chk_prox2_load: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_result_load |=> {p2h_ff, p2l_ff} == $past(result_i.prox2))
      else $error("prox2 result not captured");
   chk_prox3_load: assert property (@(posedge clock_i) disable iff (!resetn_i)
      result_i.valid |=> {p3h_ff, p3l_ff} == $past(result_i.prox3))
      else $error("prox3 result not captured");
   chk_aux_load: assert property (@(posedge clock_i) disable iff (!resetn_i)
      result_i.valid |=> {axh_ff, axl_ff} == $past(result_i.aux))
      else $error("aux result not captured");
   chk_reset_clear: assert property (@(posedge clock_i)
      $rose(resetn_i) |-> pstat_ff == 8'h00 && p2l_ff == 8'h00)
      else $error("registers not cleared at reset");
   chk_mbox_load: assert property (@(posedge clock_i) disable iff (!resetn_i)
      mbox_load_i |=> mbox_ff == $past(mbox_data_i))
      else $error("mailbox not loaded");
   chk_awake_bit: assert property (@(posedge clock_i) disable iff (!resetn_i)
      pstate_i == srsr_pkg::SRSR_AWAKE |=> pstat_ff == 8'h04)
      else $error("awake bit wrong");
   chk_reserved_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
      pstat_ff[7:3] == 5'h00)
      else $error("reserved status bits set");
   // Pin follows the enabled flags with one cycle of lag, in both directions
   chk_int_pin: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $past(resetn_i) |-> int_o == $past(|(irq_status_i & irq_enable_i)))
      else $error("interrupt pin wrong");
   chk_onehot_state: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $onehot0(pstat_ff[2:0]))
      else $error("more than one power state reported");
   chk_read_back: assert property (@(posedge clock_i) disable iff (!resetn_i)
      req_valid_i && !req_i.we && req_i.addr == `SRSR_ADDR_PSTAT |=> rvalid_o && rdata_o == $past(pstat_ff))
      else $error("status read wrong");
   chk_wait_bit: assert property (@(posedge clock_i) disable iff (!resetn_i)
      pstate_i == srsr_pkg::SRSR_WAIT |=> pstat_ff == 8'h02)
      else $error("wait bit wrong");
   chk_lowest_bit: assert property (@(posedge clock_i) disable iff (!resetn_i)
      pstate_i == srsr_pkg::SRSR_LOWEST |=> pstat_ff == 8'h01)
      else $error("lowest power bit wrong");
   // An unknown state code must clear the status, never leave a stale bit behind
   chk_bad_state: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !(pstate_i inside {srsr_pkg::SRSR_AWAKE, srsr_pkg::SRSR_WAIT, srsr_pkg::SRSR_LOWEST}) |=> pstat_ff == 8'h00)
      else $error("illegal state code reported");
   // Host writes land only when the engine is not loading in the same cycle
   chk_prox2_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_host_write(`SRSR_ADDR_PROX2_HI) ##0 !result_i.valid |=> p2h_ff == $past(req_i.wdata))
      else $error("prox2 high byte write lost");
   chk_prox3_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_host_write(`SRSR_ADDR_PROX3_HI) ##0 !result_i.valid |=> p3h_ff == $past(req_i.wdata))
      else $error("prox3 high byte write lost");
   chk_aux_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_host_write(`SRSR_ADDR_AUX_LO) ##0 !result_i.valid |=> axl_ff == $past(req_i.wdata))
      else $error("aux low byte write lost");
   // Between loads the words hold, so a late reader sees stale data, not garbage
   chk_result_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !result_i.valid && !(req_valid_i && req_i.we) |=> $stable({p2h_ff, p2l_ff}))
      else $error("prox2 word changed without a load");
   chk_mbox_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !mbox_load_i && !(req_valid_i && req_i.we) |=> $stable(mbox_ff))
      else $error("mailbox changed without a load");
   // Read answer stands one cycle, then returns to zero
   chk_mbox_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_host_read(`SRSR_ADDR_MAILBOX) |=> rvalid_o && rdata_o == $past(mbox_ff))
      else $error("mailbox read wrong");
   chk_prox2_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
      s_host_read(`SRSR_ADDR_PROX2_HI) |=> rvalid_o && rdata_o == $past(p2h_ff))
      else $error("prox2 high byte read wrong");
   chk_read_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
      !(req_valid_i && !req_i.we) |=> !rvalid_o && rdata_o == 8'h00)
      else $error("read answer without a read");
endmodule
`default_nettype wire

// ### verif/srsr_host_model.sv
// Purpose: Host side model that issues register reads and writes
// Assumes: Requests launch 1 ns after a rising edge
// Notes: A request stands for exactly one taking edge
`timescale 1ns/100ps
`default_nettype none
module srsr_host_model (
   input wire logic clock_i,
   output var logic req_valid_o,
   output var srsr_pkg::srsr_req_type req_o,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i
);
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end
   // Only registers are addressed; parameters go through commands
   task automatic access(input logic we, input logic [7:0] addr, input logic [7:0] wd, output logic [8:0] resp);
      @(posedge clock_i);
      #1;
      req_valid_o = 1'b1;
      req_o = {we, addr, wd};
      @(posedge clock_i);
      #1;
      resp = {rvalid_i, rdata_i};
      req_valid_o = 1'b0;
      // Released fields toggle so stale values cannot pass unseen
      req_o = ~req_o;
   endtask
endmodule
`default_nettype wire

// ### verif/srsr_regs_test.sv
// Purpose: Self-checking bench for the result and status registers
// Assumes: Read answer registered on the taking edge, one cycle after the request
// Notes: Host reads results right after each load except the one t_midreset clears by reset, never late
`include "srsr_params.svh"
`timescale 1ns/100ps
`default_nettype none
module srsr_regs_test;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic req_valid, rvalid, mbox_load, int_o;
   srsr_pkg::srsr_req_type req;
   srsr_pkg::srsr_result_type result = '0;
   srsr_pkg::srsr_pstate_type pstate = srsr_pkg::SRSR_LOWEST;
   logic [7:0] rdata, mbox_data = 8'h00;
   logic [5:0] irq_status = 6'h00, irq_enable = 6'h00;
   int failures = 0, n_compared = 0;
   initial mbox_load = 1'b0;
   always #25 clock_i = ~clock_i;
   srsr_regs u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .req_valid_i(req_valid), .req_i(req),
      .rdata_o(rdata), .rvalid_o(rvalid), .result_i(result), .mbox_load_i(mbox_load), .mbox_data_i(mbox_data),
      .pstate_i(pstate), .irq_status_i(irq_status), .irq_enable_i(irq_enable), .int_o(int_o));
   srsr_host_model u_host (.clock_i(clock_i), .req_valid_o(req_valid), .req_o(req), .rdata_i(rdata),
      .rvalid_i(rvalid));
   // ************************
   // Shared tasks
   // ************************
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [8:0] r;
      u_host.access(1'b0, a, 8'h00, r);
      check(r, {1'b1, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [8:0] r;
      u_host.access(1'b1, a, d, r);
      check(r, 9'h000);
   endtask
   task automatic step();
      @(posedge clock_i);
      #1;
   endtask
   // ************************
   // Scenarios
   // ************************
   task automatic t_reset();
      logic [7:0] a;
      for (a = 8'h28; a <= 8'h30; a++) begin
         if (a != `SRSR_ADDR_PSTAT) rd(a, `SRSR_RESULT_RESET);
      end
      check({8'h00, int_o}, 9'h000);
   endtask
   task automatic t_results();
      step();
      result = {1'b1, 16'hA1B2, 16'hC3D4, 16'hE5F6};
      step();
      result.valid = 1'b0;
      result.prox2 = 16'h0000;
      // Reads follow the load at once, before any further load
      rd(`SRSR_ADDR_PROX2_LO, 8'hB2);
      rd(`SRSR_ADDR_PROX2_HI, 8'hA1);
      rd(`SRSR_ADDR_PROX3_LO, 8'hD4);
      rd(`SRSR_ADDR_PROX3_HI, 8'hC3);
      rd(`SRSR_ADDR_AUX_LO, 8'hF6);
      rd(`SRSR_ADDR_AUX_HI, 8'hE5);
      wr(`SRSR_ADDR_PROX2_HI, 8'h3C);
      rd(`SRSR_ADDR_PROX2_HI, 8'h3C);
      wr(`SRSR_ADDR_PROX3_HI, 8'h96);
      rd(`SRSR_ADDR_PROX3_HI, 8'h96);
      wr(`SRSR_ADDR_AUX_LO, 8'h69);
      rd(`SRSR_ADDR_AUX_LO, 8'h69);
      step();
      check({rvalid, rdata}, 9'h000);
   endtask
   task automatic t_collide();
      logic [8:0] r;
      fork
         u_host.access(1'b1, `SRSR_ADDR_PROX2_LO, 8'h77, r);
         begin
            step();
            result = {1'b1, 16'h2468, 16'h1357, 16'h8642};
            step();
            result.valid = 1'b0;
         end
      join
      check(r, 9'h000);
      rd(`SRSR_ADDR_PROX2_LO, 8'h68);
      rd(`SRSR_ADDR_PROX2_HI, 8'h24);
      fork
         u_host.access(1'b1, `SRSR_ADDR_MAILBOX, 8'h11, r);
         begin
            step();
            mbox_load = 1'b1;
            mbox_data = 8'h99;
            step();
            mbox_load = 1'b0;
         end
      join
      check(r, 9'h000);
      rd(`SRSR_ADDR_MAILBOX, 8'h99);
   endtask
   task automatic t_mailbox();
      step();
      mbox_load = 1'b1;
      mbox_data = 8'h5A;
      step();
      mbox_load = 1'b0;
      mbox_data = 8'hA5;
      rd(`SRSR_ADDR_MAILBOX, 8'h5A);
      wr(`SRSR_ADDR_MAILBOX, 8'hC3);
      rd(`SRSR_ADDR_MAILBOX, 8'hC3);
      rd(8'h2F, 8'h00);
   endtask
   task automatic t_pstate();
      srsr_pkg::srsr_pstate_type codes[3] = '{srsr_pkg::SRSR_AWAKE, srsr_pkg::SRSR_WAIT, srsr_pkg::SRSR_LOWEST};
      foreach (codes[i]) begin
         pstate = codes[i];
         step();
         wr(`SRSR_ADDR_PSTAT, 8'hFF);
         rd(`SRSR_ADDR_PSTAT, {5'h00, codes[i]});
      end
      pstate = srsr_pkg::srsr_pstate_type'(3'h6);
      step();
      rd(`SRSR_ADDR_PSTAT, 8'h00);
      pstate = srsr_pkg::SRSR_LOWEST;
   endtask
   task automatic t_irq();
      irq_status = 6'h08;
      step();
      step();
      check({8'h00, int_o}, 9'h000);
      irq_enable = 6'h0C;
      step();
      check({8'h00, int_o}, 9'h001);
      irq_status = 6'h01;
      step();
      check({8'h00, int_o}, 9'h000);
   endtask
   task automatic t_midreset();
      step();
      result = {1'b1, 16'h1234, 16'h5678, 16'h9ABC};
      irq_status = 6'h01;
      irq_enable = 6'h01;
      step();
      result.valid = 1'b0;
      step();
      check({8'h00, int_o}, 9'h001);
      resetn_i = 1'b0;
      step();
      check({rvalid, rdata}, 9'h000);
      check({8'h00, int_o}, 9'h000);
      irq_status = 6'h00;
      step();
      resetn_i = 1'b1;
      t_reset();
   endtask
   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock_i);
      #1;
      resetn_i = 1'b1;
      t_reset();
      t_results();
      t_collide();
      t_mailbox();
      t_pstate();
      t_irq();
      t_midreset();
      conclude();
   end
endmodule
`default_nettype wire
